// File: hw/cpg_div.sv
// Purpose: serial signed divider, 64 by 32 bits, one bit per clock
// Assumes: i_den nonzero and positive
// Notes:   quotient truncates toward zero
`timescale 1ns/1ps
`include "cpg_params.svh"
module cpg_div (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  // request
  input  wire logic               i_start,
  input  wire logic signed [63:0] i_num,
  input  wire logic        [31:0] i_den,
  // answer
  output logic                    o_done,
  output logic signed [63:0]      o_quo
);
  logic [63:0] q;     // dividend shifting into quotient
  logic [32:0] rem;   // partial remainder
  logic [31:0] den;   // held divisor
  logic        neg;   // result sign
  logic [6:0]  cnt;   // steps left
  wire  [32:0] rem_sh = {rem[31:0], q[63]};
  wire         fits   = rem_sh >= {1'b0, den};
  wire  [63:0] next_q = {q[62:0], fits};

  // ****************************************
  // restoring division loop
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      q <= 64'h0; rem <= 33'h0; den <= 32'h0; neg <= 1'b0;
      cnt <= 7'h00; o_done <= 1'b0; o_quo <= 64'sh0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin  // magnitude in, sign kept aside
        q   <= i_num[63] ? 64'(-i_num) : i_num;
        neg <= i_num[63];
        den <= i_den;
        rem <= 33'h0;
        cnt <= `CPG_DIV_STEPS;
      end else if (cnt != 7'h00) begin
        q   <= next_q;
        rem <= fits ? rem_sh - {1'b0, den} : rem_sh;
        cnt <= cnt - 7'h01;
        if (cnt == 7'h01) begin  // last step
          o_quo  <= neg ? -$signed(next_q) : $signed(next_q);
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule // cpg_div

// File: hw/cpg_params.svh
// Purpose: offsets, field positions and constants of the cam generator
// Assumes: byte offsets on an 8-bit register port, 32-bit data
// Notes:   definitions only; included by the top module
`ifndef CPG_PARAMS_SVH
`define CPG_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define CPG_A_CTRL     8'h00
`define CPG_A_CAM_REQ  8'h04
`define CPG_A_STROKE   8'h08
`define CPG_A_STD_INIT 8'h0C
`define CPG_A_CAM_SEL  8'h10
`define CPG_A_CAM_CFG  8'h14
`define CPG_A_PT_ADDR  8'h18
`define CPG_A_PT_DATA  8'h1C
`define CPG_A_ENC_UNIT 8'h20
`define CPG_A_STATUS   8'h24
`define CPG_A_FEED     8'h28
`define CPG_A_STD      8'h2C
// ****************************************
// per-cam setup word fields
// ****************************************
`define CPG_CFG_TYPE      0
`define CPG_CFG_RES_LSB   1
`define CPG_CFG_RES_MSB   2
`define CPG_CFG_START_LSB 3
`define CPG_CFG_START_MSB 13
`define CPG_CFG_COUNT_LSB 14
`define CPG_CFG_COUNT_MSB 24
`define CPG_SEL_COMMIT    4
// ****************************************
// reset values and arithmetic constants
// ****************************************
`define CPG_CFG_RST    25'h0000000
`define CPG_ENC_RST    16'h0000
`define CPG_PHASE_FULL 17'h10000
`define CPG_PHASE_HALF 16'h8000
`define CPG_RES_BASE   12'h100
`define CPG_SHIFT_BASE 4'h8
`define CPG_SCALE_LSB  16
`define CPG_SCALE_MSB  47
`define CPG_CAM_MAX    4'h8
`define CPG_DIV_STEPS  7'h40
`endif

// File: hw/cpg_pkg.sv
// Purpose: shared types of the cam generator
// Assumes: nothing beyond the params header
// Notes:   gray codes along the usual evaluation path
package cpg_pkg;
  // evaluation engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SCAN = 3'b001,
    ST_LOAD = 3'b011,
    ST_DIV  = 3'b010,
    ST_DONE = 3'b110
  } cpg_state_type;
  // which point of the cycle is being evaluated
  typedef enum logic [1:0] {
    EV_END   = 2'b00,
    EV_ZERO  = 2'b01,
    EV_PHASE = 2'b11
  } cpg_eval_type;
endpackage

// File: hw/cpg_sync.sv
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to i_clk
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module cpg_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // level in and out
  input  wire logic i_d,
  output logic      o_q
);
  logic meta;  // first stage, read by o_q only

  // ****************************************
  // two stages
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta <= 1'b0;
      o_q  <= 1'b0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // cpg_sync

// File: hw/cpg_top.sv
// Purpose: cam feed position from a stored profile, once per tick
// Assumes: I_CYCLE_VAL is a 16-bit cycle phase, 65536 = one cycle
// Notes:   ratios are Q16 (65536 = 100%); forward wrap only
//
// What this block does
// - stroke wrap adds stroke times last ratio
// - start index shifts stroke profile point zero
// - coordinate profiles ignore the start index
// - start index reloads from committed setup at reset
// - stroke mode latches cam and stroke on command
// - stroke base moves only when passing point zero
// - cam zero is a straight line to 100%
// - cams one to eight are stored profiles
// - outside points extrapolate from nearest two
// - coordinate feed is base plus output
// - interpolate between neighbouring points
// - coordinate wrap adds end minus zero output
// - coordinate mode latches cam number only
// - power-cycle items apply only after reset
// - uncommitted edits vanish at reset; only setup words revert, profile point data has no reset and is kept
// - stroke feed is base plus stroke times ratio
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "cpg_params.svh"
module cpg_top (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_NV_ERASE,
  // register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  // cam axis
  input  wire logic        I_CAM_RUN,
  input  wire logic        I_TICK,
  input  wire logic [15:0] I_CYCLE_VAL,
  output logic [31:0]      O_FEED_POS,
  output logic             O_FEED_VALID,
  output logic [31:0]      O_STD_POS,
  output logic [3:0]       O_CAM_ACTIVE
);
  import cpg_pkg::*;

  // ****************************************
  // storage and state
  // ****************************************
  logic [31:0] mem [0:32767];   // 4096 words per cam
  logic [24:0] cfg_work [0:7];  // setup in use
  logic [24:0] cfg_nv [0:7];    // committed setup, survives reset
  logic [31:0] ld_w [0:3];      // fetched segment words
  logic [31:0] mem_q;           // profile read data
  logic        enable;          // software run enable
  logic [3:0]  cam_req;         // cam number for next command
  logic [31:0] stroke_req;      // stroke for next command
  logic [31:0] std_init;        // base position at start
  logic [2:0]  cam_sel;         // cam being edited
  logic        commit;          // edits also go to nv copy
  logic [11:0] pt_addr;         // edit pointer
  logic [15:0] enc_nv;          // committed unit select
  logic [15:0] enc_active;      // unit select in force
  logic [3:0]  pend_cam;        // latched cam number
  logic [31:0] pend_stroke;     // latched stroke
  logic        pend_valid;      // latched pair waits for wrap
  logic [3:0]  cam;             // active cam
  logic [31:0] stroke;          // active stroke
  logic [31:0] std;             // standard position
  logic        running;         // first tick seen
  cpg_state_type state;         // engine state
  cpg_eval_type  ev_step;       // point being evaluated
  logic        go;              // launch pending
  logic [15:0] ph;              // phase of this tick
  logic [10:0] k;               // coordinate segment
  logic        sub;             // scan read phase
  logic [2:0]  ld_cnt;          // words fetched
  logic        div_run;         // divider started
  logic [31:0] ev_val;          // evaluated profile value
  logic [31:0] ve;              // value at cycle end
  logic        run_s;           // synced command
  logic        run_d;           // previous command level
  logic        div_done;
  logic signed [63:0] div_q;

  // ****************************************
  // register decode
  // ****************************************
  wire wr_ctrl  = I_WR && (I_ADDR == `CPG_A_CTRL);
  wire wr_req   = I_WR && (I_ADDR == `CPG_A_CAM_REQ);
  wire wr_strk  = I_WR && (I_ADDR == `CPG_A_STROKE);
  wire wr_init  = I_WR && (I_ADDR == `CPG_A_STD_INIT);
  wire wr_sel   = I_WR && (I_ADDR == `CPG_A_CAM_SEL);
  wire wr_cfg   = I_WR && (I_ADDR == `CPG_A_CAM_CFG);
  wire wr_ptad  = I_WR && (I_ADDR == `CPG_A_PT_ADDR);
  wire wr_data  = I_WR && (I_ADDR == `CPG_A_PT_DATA);
  wire wr_enc   = I_WR && (I_ADDR == `CPG_A_ENC_UNIT);
  wire busy     = (state != ST_IDLE) || go;
  wire [31:0] rd_mux =
    (I_ADDR == `CPG_A_CTRL)     ? {31'h0, enable} :
    (I_ADDR == `CPG_A_CAM_REQ)  ? {28'h0, cam_req} :
    (I_ADDR == `CPG_A_STROKE)   ? stroke_req :
    (I_ADDR == `CPG_A_STD_INIT) ? std_init :
    (I_ADDR == `CPG_A_CAM_SEL)  ? {27'h0, commit, 1'b0, cam_sel} :
    (I_ADDR == `CPG_A_CAM_CFG)  ? {7'h0, cfg_work[cam_sel]} :
    (I_ADDR == `CPG_A_PT_ADDR)  ? {20'h0, pt_addr} :
    (I_ADDR == `CPG_A_ENC_UNIT) ? {16'h0, enc_active} :
    (I_ADDR == `CPG_A_STATUS)   ?
      {25'h0, running, busy, pend_valid, cam} :
    (I_ADDR == `CPG_A_FEED)     ? O_FEED_POS :
    (I_ADDR == `CPG_A_STD)      ? std : 32'h0;

  // ****************************************
  // active profile fields
  // ****************************************
  wire [2:0]  cam_idx  = 3'(cam - 4'h1);
  wire [24:0] acfg     = cfg_work[cam_idx];
  wire        is_lin   = (cam == 4'h0);
  wire        is_coord = !is_lin && acfg[`CPG_CFG_TYPE];
  wire [1:0]  rc       = acfg[`CPG_CFG_RES_MSB:`CPG_CFG_RES_LSB];
  wire [3:0]  sh       = `CPG_SHIFT_BASE - {2'b0, rc};
  wire [11:0] res      = `CPG_RES_BASE << rc;
  wire [11:0] start    = {1'b0, acfg[`CPG_CFG_START_MSB:`CPG_CFG_START_LSB]};
  wire [10:0] ncoord   = acfg[`CPG_CFG_COUNT_MSB:`CPG_CFG_COUNT_LSB];

  // ****************************************
  // segment selection
  // ****************************************
  wire [16:0] ev_x = (ev_step == EV_END)  ? `CPG_PHASE_FULL :
                     (ev_step == EV_ZERO) ? 17'h00000 : {1'b0, ph};
  wire        ev_raw  = (ev_step != EV_PHASE);
  wire [11:0] idx_raw = 12'(ev_x >> sh);
  wire [11:0] seg     = (idx_raw == res) ? res - 12'h001 : idx_raw;
  // start offset only on the running phase, masked into the table
  wire [11:0] seg_mem = ev_raw ? seg : ((seg + start) & (res - 12'h001));
  wire [31:0] sx0     = {20'h0, seg} << sh;
  wire [31:0] sx1     = sx0 + (32'h1 << sh);
  wire [11:0] k2      = {k, 1'b0};
  wire [11:0] ld_off  = is_coord ? k2 + {9'h0, ld_cnt} :
                        seg_mem + {9'h0, ld_cnt};
  wire [11:0] rd_off  = (state == ST_SCAN) ? k2 + 12'h002 : ld_off;
  wire [14:0] rd_addr = {cam_idx, rd_off};
  wire [2:0]  ld_last = is_coord ? 3'h4 : 3'h2;
  // below the first point or past the last: edge segment extends
  wire scan_stop = ($signed({15'h0, ev_x}) < $signed(mem_q)) ||
                   (k == ncoord - 11'h002);

  // ****************************************
  // interpolation operands
  // ****************************************
  wire signed [31:0] ix0 = is_coord ? ld_w[0] : sx0;
  wire signed [31:0] iy0 = is_coord ? ld_w[1] : ld_w[0];
  wire signed [31:0] ix1 = is_coord ? ld_w[2] : sx1;
  wire signed [31:0] iy1 = is_coord ? ld_w[3] : ld_w[1];
  wire signed [63:0] dy  = 64'(iy1) - 64'(iy0);
  wire signed [63:0] dx  = 64'($signed({15'h0, ev_x})) - 64'(ix0);
  wire signed [63:0] num = dy * dx;
  wire [31:0] den = 32'(ix1 - ix0);
  wire div_start  = (state == ST_DIV) && !div_run;
  wire [31:0] iv  = 32'(iy0 + div_q[31:0]);

  // ****************************************
  // position arithmetic
  // ****************************************
  wire signed [63:0] sprod = 64'($signed(stroke)) * 64'($signed(ev_val));
  wire [31:0] sval     = sprod[`CPG_SCALE_MSB:`CPG_SCALE_LSB];
  wire [31:0] feed_crd = std + ev_val;
  wire [31:0] feed_str = std + sval;
  wire [31:0] std_crd  = std + ve - ev_val;
  wire [31:0] next_std = is_coord ? std_crd : feed_str;
  wire apply = (state == ST_DONE) &&
               (((ev_step == EV_END) && !is_coord) || (ev_step == EV_ZERO));
  wire wrap  = (I_CYCLE_VAL < ph) && ((ph - I_CYCLE_VAL) >= `CPG_PHASE_HALF);
  wire tick_ok   = (state == ST_IDLE) && !go && I_TICK && enable;
  wire start_run = tick_ok && !running;

  // ****************************************
  // command input
  // ****************************************
  wire run_rise  = run_s && !run_d;
  wire [2:0] req_idx = 3'(cam_req - 4'h1);
  wire req_coord = (cam_req != 4'h0) && cfg_work[req_idx][`CPG_CFG_TYPE];
  wire take      = run_rise && (cam_req <= `CPG_CAM_MAX);

  cpg_sync u_sync (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_d       (I_CAM_RUN),
    .o_q       (run_s)
  );

  cpg_div u_div (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_start   (div_start),
    .i_num     (num),
    .i_den     (den),
    .o_done    (div_done),
    .o_quo     (div_q)
  );

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      enable <= 1'b0; cam_req <= 4'h0; stroke_req <= 32'h0;
      std_init <= 32'h0; cam_sel <= 3'h0; commit <= 1'b0; pt_addr <= 12'h0;
    end else begin
      if (wr_ctrl) enable <= I_WDATA[0];
      if (wr_req) cam_req <= I_WDATA[3:0];
      if (wr_strk) stroke_req <= I_WDATA;
      if (wr_init) std_init <= I_WDATA;
      if (wr_sel) begin
        cam_sel <= I_WDATA[2:0];
        commit  <= I_WDATA[`CPG_SEL_COMMIT];
      end
      if (wr_data) pt_addr <= pt_addr + 12'h001;  // auto step
      else if (wr_ptad) pt_addr <= I_WDATA[11:0];
    end
  end

  // profile RAM, one write and one read per clock
  always_ff @(posedge I_CLK) begin
    if (wr_data) mem[{cam_sel, pt_addr}] <= I_WDATA;
    mem_q <= mem[rd_addr];
  end

  // setup words: working copy reloads from committed copy at reset
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_cfg
      wire sel_g = wr_cfg && (cam_sel == 3'(g));
      always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) cfg_work[g] <= cfg_nv[g];
        else if (sel_g) cfg_work[g] <= I_WDATA[24:0];
      end
      always_ff @(posedge I_CLK) begin
        if (I_NV_ERASE) cfg_nv[g] <= `CPG_CFG_RST;
        else if (sel_g && commit) cfg_nv[g] <= I_WDATA[24:0];
      end
    end
  endgenerate

  // unit select: writes only reach the stored copy
  always_ff @(posedge I_CLK) begin
    if (I_NV_ERASE) enc_nv <= `CPG_ENC_RST;
    else if (wr_enc) enc_nv <= I_WDATA[15:0];
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) enc_active <= enc_nv;
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) O_RDATA <= 32'h0;
    else O_RDATA <= I_RD ? rd_mux : 32'h0;
  end

  // ****************************************
  // latched command, applied at the wrap
  // ****************************************
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      run_d <= 1'b0; pend_cam <= 4'h0;
      pend_stroke <= 32'h0; pend_valid <= 1'b0;
    end else begin
      run_d <= run_s;
      if (take) begin  // a new command beats the consuming wrap
        pend_cam   <= cam_req;
        pend_valid <= 1'b1;
        if (!req_coord) pend_stroke <= stroke_req;
      end else if (apply || start_run) pend_valid <= 1'b0;
    end
  end

  // active cam, stroke and standard position
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      cam <= 4'h0; stroke <= 32'h0; std <= 32'h0; running <= 1'b0;
    end else if (start_run) begin
      cam <= pend_cam; stroke <= pend_stroke;
      std <= std_init; running <= 1'b1;
    end else if (apply) begin  // only at the cycle boundary
      std <= next_std;
      if (pend_valid) begin
        cam    <= pend_cam;
        stroke <= pend_stroke;
      end
    end else if (!enable && (state == ST_IDLE)) running <= 1'b0;
  end

  // fetched words are data, no reset needed
  always_ff @(posedge I_CLK) begin
    if ((state == ST_LOAD) && (ld_cnt != 3'h0)) ld_w[2'(ld_cnt - 3'h1)] <= mem_q;
  end

  // ****************************************
  // evaluation engine
  // ****************************************
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state <= ST_IDLE; ev_step <= EV_PHASE; go <= 1'b0; ph <= 16'h0;
      k <= 11'h0; sub <= 1'b0; ld_cnt <= 3'h0; div_run <= 1'b0;
      ev_val <= 32'h0; ve <= 32'h0;
      O_FEED_POS <= 32'h0; O_FEED_VALID <= 1'b0;
    end else begin
      O_FEED_VALID <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (go) begin  // launch per the active profile type
            go <= 1'b0; k <= 11'h0; sub <= 1'b0; ld_cnt <= 3'h0;
            if (is_lin) begin
              ev_val <= {15'h0, ev_x};
              state  <= ST_DONE;
            end else if (is_coord) state <= ST_SCAN;
            else state <= ST_LOAD;
          end else if (tick_ok) begin
            ph <= I_CYCLE_VAL;
            go <= 1'b1;
            ev_step <= (running && wrap) ? EV_END : EV_PHASE;
          end
        end
        ST_SCAN: begin  // two clocks per point: address, compare
          sub <= !sub;
          if (sub) begin
            if (scan_stop) state <= ST_LOAD;
            else k <= k + 11'h001;
          end
        end
        ST_LOAD: begin
          ld_cnt <= ld_cnt + 3'h1;
          if (ld_cnt == ld_last) state <= ST_DIV;
        end
        ST_DIV: begin
          div_run <= 1'b1;
          if (div_done) begin
            ev_val  <= iv;
            div_run <= 1'b0;
            state   <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
          case (ev_step)
            EV_END: begin
              ve <= ev_val;
              ev_step <= is_coord ? EV_ZERO : EV_PHASE;
              go <= 1'b1;
            end
            EV_ZERO: begin
              ev_step <= EV_PHASE;
              go <= 1'b1;
            end
            default: begin  // one result per tick
              O_FEED_POS   <= is_coord ? feed_crd : feed_str;
              O_FEED_VALID <= 1'b1;
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign O_STD_POS    = std;
  assign O_CAM_ACTIVE = cam;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire done_ph  = (state == ST_DONE) && (ev_step == EV_PHASE);
  wire lin_go   = (state == ST_IDLE) && go && is_lin;
  wire div_rise = (state == ST_DIV) && !div_run;

  a_stroke_wrap: assert property ((apply && !is_coord) |=>
    std == $past(feed_str)) else $error("stroke wrap base wrong");
  a_coord_wrap: assert property ((apply && is_coord) |=>
    std == $past(std_crd)) else $error("coord wrap base wrong");
  a_base_hold: assert property ((!apply && !start_run) |=>
    std == $past(std)) else $error("base moved off the wrap");
  a_coord_feed: assert property ((done_ph && is_coord) |=>
    O_FEED_VALID && O_FEED_POS == $past(std) + $past(ev_val))
    else $error("coord feed wrong");
  a_stroke_feed: assert property ((done_ph && !is_coord) |=>
    O_FEED_VALID && O_FEED_POS == $past(std) + $past(sval))
    else $error("stroke feed wrong");
  a_cmd_latch: assert property (take |=>
    pend_valid && pend_cam == $past(cam_req)) else $error("cmd not taken");
  a_coord_stroke: assert property ((take && req_coord) |=>
    $stable(pend_stroke)) else $error("coord cmd moved stroke");
  a_cam_boundary: assert property (!apply && !start_run |=>
    $stable(cam) && $stable(stroke)) else $error("cam changed mid cycle");
  a_linear_val: assert property (lin_go |=>
    state == ST_DONE && ev_val == {15'h0, $past(ev_x)})
    else $error("linear cam value wrong");
  a_div_bound: assert property (div_rise |-> ##[65:67]
    state == ST_DONE) else $error("divide overran");
  a_unit_hold: assert property ($stable(enc_active))
    else $error("unit select changed without reset");

  c_wrap_stroke: cover property (apply && !is_coord);
  c_wrap_coord: cover property (apply && is_coord);
  c_cam_switch: cover property (apply && pend_valid);
  c_feed: cover property (O_FEED_VALID);
endmodule // cpg_top

// File: testbench/cpg_cmd_model.sv
// Purpose: positioning controller that raises the cam run pin
// Assumes: bench pulses i_go for one clock per command
// Notes:   pin held six clocks so the two-flop sync sees it
`timescale 1ns/1ps
module cpg_cmd_model (
  // clock
  input  wire logic i_clk,
  // request from bench
  input  wire logic i_go,
  // cam run pin
  output logic      o_cam_run
);
  logic [2:0] hold_cnt = 3'h0; // clocks left high
  // stretch each request; a one-clock level could slip past the sync
  always_ff @(posedge i_clk) begin
    if (i_go) begin
      hold_cnt <= 3'h6;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end
  end
  assign o_cam_run = (hold_cnt != 3'h0);
endmodule // cpg_cmd_model

// File: testbench/test_cpg_top.sv
// Purpose: bench for the cam profile position generator
// Assumes: Q16 ratios, 256-point stroke cam in slot one
// Notes:   expected figures worked by hand from the ratios
`timescale 1ns/1ps
`include "cpg_params.svh"
module test_cpg_top;
  logic        I_CLK = 1'b0, I_RESET_N = 1'b0, I_NV_ERASE = 1'b1;
  logic [7:0]  I_ADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0;
  logic        I_WR = 1'b0, I_RD = 1'b0, I_TICK = 1'b0, go = 1'b0;
  logic [15:0] I_CYCLE_VAL = 16'h0;
  logic [31:0] O_RDATA, O_FEED_POS, O_STD_POS;
  logic [3:0]  O_CAM_ACTIVE;
  logic        O_FEED_VALID, cam_run;
  int          fail_count = 0, n_checks = 0;
  cpg_top u_cpg_top (.I_CLK, .I_RESET_N, .I_NV_ERASE, .I_ADDR, .I_WDATA,
    .I_WR, .I_RD, .O_RDATA, .I_CAM_RUN(cam_run), .I_TICK, .I_CYCLE_VAL,
    .O_FEED_POS, .O_FEED_VALID, .O_STD_POS, .O_CAM_ACTIVE);
  cpg_cmd_model u_cpg_cmd_model (.i_clk(I_CLK), .i_go(go),
    .o_cam_run(cam_run));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  // read data stand only in the clock after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, e);
  endtask
  task automatic cmd;
    @(posedge I_CLK);
    go <= 1'b1;
    @(posedge I_CLK);
    go <= 1'b0;
    repeat (12) @(posedge I_CLK);
  endtask
  // one control tick, then feed, base and cam compared
  task automatic tick(input logic [15:0] ph, input logic [31:0] f,
                      input logic [31:0] s, input logic [3:0] c);
    int n;
    @(posedge I_CLK);
    I_TICK <= 1'b1;
    I_CYCLE_VAL <= ph;
    @(posedge I_CLK);
    I_TICK <= 1'b0;
    for (n = 0; n < 3000 && O_FEED_VALID !== 1'b1; n++) begin
      @(posedge I_CLK);
      #1;
    end
    if (n == 3000) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end else begin
      chk(O_FEED_POS, f);
      chk(O_STD_POS, s);
      chk({28'h0, O_CAM_ACTIVE}, {28'h0, c});
      repeat (20) @(posedge I_CLK);
    end
  endtask
  // ****************************************
  // clock and main sequence
  // ****************************************
  initial forever #50 I_CLK = ~I_CLK;
  initial begin
    repeat (8) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    I_NV_ERASE <= 1'b0;
    rd(`CPG_A_CAM_CFG, 32'h0);
    wr(`CPG_A_ENC_UNIT, 32'h1);
    rd(`CPG_A_ENC_UNIT, 32'h0);
    rd(8'h30, 32'h0);
    wr(`CPG_A_STROKE, 32'h1000);
    cmd();
    wr(`CPG_A_STD_INIT, 32'h64);
    wr(`CPG_A_CTRL, 32'h1);
    tick(16'h4000, 32'h464, 32'h64, 4'h0);
    tick(16'hF000, 32'hF64, 32'h64, 4'h0);
    tick(16'h1000, 32'h1164, 32'h1064, 4'h0);
    $display("test linear cam done");
    wr(`CPG_A_CAM_SEL, 32'h0);
    wr(`CPG_A_CAM_CFG, 32'h80);
    wr(`CPG_A_PT_ADDR, 32'h0);
    // ramp that drops back to 0% at the last point: to-and-fro cam
    for (int i = 0; i <= 256; i++) wr(`CPG_A_PT_DATA, (i % 256) * 256);
    wr(`CPG_A_CAM_REQ, 32'h1);
    wr(`CPG_A_STROKE, 32'h2000);
    cmd();
    tick(16'hF000, 32'h1F64, 32'h1064, 4'h0);
    tick(16'h0000, 32'h2264, 32'h2064, 4'h1);
    tick(16'h0080, 32'h2274, 32'h2064, 4'h1);
    tick(16'h8000, 32'h3264, 32'h2064, 4'h1);
    tick(16'h0000, 32'h2264, 32'h2064, 4'h1);
    $display("test stored cam done");
    // coordinate cam in slot two: three points, both ends extrapolated
    wr(`CPG_A_CAM_SEL, 32'h1);
    wr(`CPG_A_CAM_CFG, 32'hC029);
    wr(`CPG_A_PT_ADDR, 32'h0);
    wr(`CPG_A_PT_DATA, 32'h4000);
    wr(`CPG_A_PT_DATA, 32'h100);
    wr(`CPG_A_PT_DATA, 32'h8000);
    wr(`CPG_A_PT_DATA, 32'h300);
    wr(`CPG_A_PT_DATA, 32'hC000);
    wr(`CPG_A_PT_DATA, 32'h100);
    wr(`CPG_A_CAM_REQ, 32'h2);
    wr(`CPG_A_STROKE, 32'h5555);
    cmd();
    tick(16'h8000, 32'h3264, 32'h2064, 4'h1);
    tick(16'h0000, 32'h1F64, 32'h2064, 4'h2);
    tick(16'h6000, 32'h2264, 32'h2064, 4'h2);
    tick(16'hE000, 32'h2064, 32'h2064, 4'h2);
    tick(16'h2800, 32'h20A4, 32'h2064, 4'h2);
    $display("test coordinate cam done");
    @(posedge I_CLK);
    I_RESET_N <= 1'b0;
    repeat (4) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    rd(`CPG_A_ENC_UNIT, 32'h1);
    rd(`CPG_A_CAM_CFG, 32'h0);
    $display("test reload done");
    wrap_up();
  end
endmodule // test_cpg_top
